//--- rtl/sarr_core.sv
// Serial register port with live status, alert mask and readback select.
// Assumes a 32-bit word per 32 serial clocks, data taken on the falling edge.
// Assumes the serial pins and live conditions are asynchronous to clk.
`timescale 1ns/100ps
module sarr_core (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire sarr_pkg::sarr_live_s live_cond,
   input wire logic [3:0] din_comp,
   input wire logic [14:0] alert_status,
   output logic alert_n,
   output logic [15:0] alert_mask_bits,
   output sarr_pkg::sarr_rbsel_s readback_select
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      sarr_pkg::sarr_state_e st;
      logic sclk_d;
      logic [4:0] bitcnt;
      logic [31:0] shin;
      logic [31:0] shout;
      logic pend;
      logic [7:0] rd_addr;
      logic [15:0] mask;
      sarr_pkg::sarr_rbsel_s rbsel;
   } sarr_core_s;

   sarr_core_s q;
   sarr_core_s next_q;

   logic [22:0] sync_bus;
   logic s_sclk;
   logic s_sync_n;
   logic s_sdi;
   sarr_pkg::sarr_live_s s_live;
   logic [3:0] s_din;
   logic alert_pending;
   logic sclk_fall;
   logic frame_start;
   logic word_done;
   logic load;
   sarr_pkg::sarr_in_word_s in_word;
   logic wr_mask;
   logic wr_rbsel;

   // ---------------------------------------------------------------
   // Synchronisers and alert gate
   // ---------------------------------------------------------------
   // Live conditions pass the same two stages as the pins; two cycles of lag
   // are invisible against a serial word of several microseconds.
   // The frame select travels inverted, so the flushed synchroniser reads as no frame
   // instead of opening a false frame in the first cycles after reset.
   sarr_sync #(
      .WIDTH(23)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({sclk, ~sync_n, sdi, live_cond, din_comp}),
      .sync_out(sync_bus)
   );

   assign s_sclk = sync_bus[22];
   assign s_sync_n = ~sync_bus[21];
   assign s_sdi = sync_bus[20];
   assign s_live = sarr_pkg::sarr_live_s'(sync_bus[19:4]);
   assign s_din = sync_bus[3:0];

   sarr_alert_gate u_gate (
      .clk(clk),
      .rst_n(rst_n),
      .alert_status(alert_status),
      .alert_mask(q.mask[14:0]),
      .alert_n(alert_n),
      .alert_pending(alert_pending)
   );

   // ---------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------
   function automatic logic [15:0] read_reg(
      input logic [7:0] addr,
      input logic [15:0] mask,
      input sarr_pkg::sarr_rbsel_s rbsel,
      input sarr_pkg::sarr_live_s live
   );
      logic [15:0] v;
      v = sarr_pkg::DATA_NONE;
      case (addr)
         sarr_pkg::ADDR_LIVE: begin
            v = {1'b0, live[14:0]};
         end
         sarr_pkg::ADDR_MASK: begin
            v = mask & sarr_pkg::MASK_WMASK;
         end
         sarr_pkg::ADDR_RBSEL: begin
            v = rbsel & sarr_pkg::RBSEL_WMASK;
         end
         default: begin
            v = sarr_pkg::DATA_NONE;
         end
      endcase
      return v;
   endfunction

   function automatic logic [31:0] build_word(
      input logic [7:0] addr,
      input logic show,
      input logic [15:0] mask,
      input sarr_pkg::sarr_rbsel_s rbsel,
      input sarr_pkg::sarr_live_s live,
      input sarr_pkg::sarr_info_s info
   );
      sarr_pkg::sarr_out_word_s w;
      w.zero = 1'b0;
      w.pad = 8'h00;
      if (rbsel.frame_header_select) begin
         w.header = info;
      end else begin
         w.header = rbsel.rb_addr[6:0];
      end
      w.data = show ? read_reg(addr, mask, rbsel, live) : sarr_pkg::DATA_NONE;
      return w;
   endfunction

   assign sclk_fall = ~s_sclk & q.sclk_d;
   assign frame_start = (q.st == sarr_pkg::SARR_IDLE) && !s_sync_n;
   assign word_done = (q.st == sarr_pkg::SARR_SHIFT) && !s_sync_n && sclk_fall && (q.bitcnt == sarr_pkg::BIT_LAST);
   assign load = frame_start || word_done;
   assign in_word = sarr_pkg::sarr_in_word_s'({q.shin[30:0], s_sdi});
   assign wr_mask = word_done && (in_word.addr == sarr_pkg::ADDR_MASK);
   assign wr_rbsel = word_done && (in_word.addr == sarr_pkg::ADDR_RBSEL);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      sarr_pkg::sarr_info_s info;
      sarr_pkg::sarr_rbsel_s rbsel_n;
      logic [7:0] addr_n;
      logic show;
      info = '0;
      rbsel_n = q.rbsel;
      addr_n = q.rd_addr;
      show = 1'b0;
      next_q = q;
      next_q.sclk_d = s_sclk;
      info.adc_rdy = s_live.adc_rdy;
      info.alert_pending = alert_pending;
      info.alert_any = |alert_status;
      info.din_comp = s_din;
      case (q.st)
         sarr_pkg::SARR_IDLE: begin
            if (!s_sync_n) begin
               // A new burst always restarts at the readback address.
               addr_n = q.rbsel.rb_addr;
               show = q.rbsel.auto_read || q.pend;
               next_q.st = sarr_pkg::SARR_SHIFT;
               next_q.bitcnt = sarr_pkg::BIT_FIRST;
               next_q.rd_addr = addr_n;
               next_q.shout = build_word(addr_n, show, q.mask, q.rbsel, s_live, info);
            end
         end
         sarr_pkg::SARR_SHIFT: begin
            if (s_sync_n) begin
               // A partial word is dropped; nothing it carried is written.
               next_q.st = sarr_pkg::SARR_IDLE;
            end else if (sclk_fall) begin
               next_q.shin = in_word;
               next_q.shout = {q.shout[30:0], 1'b0};
               next_q.bitcnt = 5'(q.bitcnt + sarr_pkg::BIT_STEP);
               if (q.bitcnt == sarr_pkg::BIT_FIRST) begin
                  next_q.pend = 1'b0;
               end
               if (word_done) begin
                  if (wr_mask) begin
                     next_q.mask = in_word.data & sarr_pkg::MASK_WMASK;
                  end
                  if (wr_rbsel) begin
                     rbsel_n = sarr_pkg::sarr_rbsel_s'(in_word.data & sarr_pkg::RBSEL_WMASK);
                  end
                  // The written word is already out, so the new setting only shapes the next one.
                  next_q.rbsel = rbsel_n;
                  next_q.pend = wr_rbsel && !rbsel_n.auto_read;
                  if (rbsel_n.auto_read) begin
                     addr_n = q.rbsel.auto_read ? 8'(q.rd_addr + sarr_pkg::ADDR_STEP) : rbsel_n.rb_addr;
                  end else begin
                     addr_n = rbsel_n.rb_addr;
                  end
                  show = rbsel_n.auto_read || wr_rbsel;
                  next_q.rd_addr = addr_n;
                  next_q.bitcnt = sarr_pkg::BIT_FIRST;
                  next_q.shout = build_word(addr_n, show, next_q.mask, rbsel_n, s_live, info);
               end
            end
         end
         default: begin
            next_q.st = sarr_pkg::SARR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
         q.mask <= sarr_pkg::MASK_RESET;
         q.rbsel <= sarr_pkg::RBSEL_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign sdo = q.shout[31];
   assign sdo_oe = (q.st == sarr_pkg::SARR_SHIFT);
   assign alert_mask_bits = q.mask;
   assign readback_select = q.rbsel;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_open;
      frame_start ##1 (q.st == sarr_pkg::SARR_SHIFT);
   endsequence

   sequence s_live_load;
      frame_start && q.rbsel.auto_read && (q.rbsel.rb_addr == sarr_pkg::ADDR_LIVE);
   endsequence

   property p_open_drives;
      s_open |-> sdo_oe && !sdo;
   endproperty
   a_open_drives: assert property (p_open_drives) else $error("frame opened without driving sdo");

   property p_live_mirror;
      s_live_load |=> q.shout[14:0] == $past(s_live[14:0]) && !q.shout[15];
   endproperty
   a_live_mirror: assert property (p_live_mirror) else $error("live status word does not match conditions");

   property p_overheat;
      s_live_load |=> q.shout[4] == $past(s_live.overheat_live);
   endproperty
   a_overheat: assert property (p_overheat) else $error("overheat bit does not follow its condition");

   property p_chan_faults;
      s_live_load ##0 (s_live[3:0] != 4'h0) |=> q.shout[3:0] == $past(s_live[3:0]);
   endproperty
   a_chan_faults: assert property (p_chan_faults) else $error("channel fault bits wrong");

   property p_mask_reserved;
      !q.mask[15] && (q.rbsel.rsvd == 6'h00);
   endproperty
   a_mask_reserved: assert property (p_mask_reserved) else $error("reserved bit set");

   property p_reset_values;
      $rose(rst_n) |-> ((q.mask == sarr_pkg::MASK_RESET) && (q.rbsel == sarr_pkg::RBSEL_RESET))
         ##1 !sdo_oe ##1 !sdo_oe;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("registers not at reset value");

   property p_two_stage_quiet;
      (word_done && !q.rbsel.auto_read && !wr_rbsel) |=> q.shout[15:0] == sarr_pkg::DATA_NONE;
   endproperty
   a_two_stage_quiet: assert property (p_two_stage_quiet) else $error("data returned outside two-stage read");

   property p_burst_step;
      (word_done && q.rbsel.auto_read && !wr_rbsel) |=> q.rd_addr == 8'($past(q.rd_addr) + sarr_pkg::ADDR_STEP);
   endproperty
   a_burst_step: assert property (p_burst_step) else $error("burst address did not step by one");

   property p_burst_restart;
      frame_start |=> q.rd_addr == $past(q.rbsel.rb_addr);
   endproperty
   a_burst_restart: assert property (p_burst_restart) else $error("burst did not restart at readback address");

   property p_header_addr;
      (load && !next_q.rbsel.frame_header_select) |=> q.shout[30:24] == q.rbsel.rb_addr[6:0];
   endproperty
   a_header_addr: assert property (p_header_addr) else $error("header does not carry readback address");

   property p_header_info;
      (load && next_q.rbsel.frame_header_select) |=> q.shout[27:24] == $past(s_din);
   endproperty
   a_header_info: assert property (p_header_info) else $error("header does not carry comparator outputs");

   property p_write_own_word;
      (sclk_fall && !s_sync_n && (q.st == sarr_pkg::SARR_SHIFT) && !word_done)
         |=> q.shout == {$past(q.shout[30:0]), 1'b0};
   endproperty
   a_write_own_word: assert property (p_write_own_word) else $error("outgoing word changed mid-shift");

endmodule

//--- rtl/sarr_pkg.sv
// Summary of operation
// - Live status bits 8 to 5 show the digital supply, analog supply, 5 V regulator and charge pump faults as they are now.
// - Live status bit 4 is high while the die temperature indication says 115 C or more.
// - Live status bits 3 to 0 show the present fault state of channels D, C, B and A.
// - Live status bits are never latched and follow their conditions with no software clear.
// - A set mask bit keeps its alert status bit off the alert pin, a clear one lets it through.
// - Each mask bit sits at the same position as the alert status bit it covers.
// - The alert mask register resets to zero, bit 15 reads zero and bits 14 to 0 are writable.
// - Bits 7 to 0 of the readback select register hold the address whose contents are returned.
// - With automatic read off, data comes back only in the word right after a readback select write.
// - With automatic read on, every word returns the data at the current read address.
// - In an automatic burst the read address starts at the readback address and steps by one each word.
// - With the header select bit clear, read word bits 30 to 24 carry the readback address.
// - With the header select bit set, bits 30 to 24 carry converter ready, alert flags and four comparators.
// - The readback select register resets to zero and bits 15 to 10 read zero.
//
// Constants and carrier types of the status, alert mask and readback block.
// Assumes one 100 MHz device clock and a serial host clock far slower than it.
package sarr_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_LIVE = 8'h2F;
   localparam logic [7:0] ADDR_MASK = 8'h3C;
   localparam logic [7:0] ADDR_RBSEL = 8'h41;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] MASK_WMASK = 16'h7FFF;
   localparam logic [15:0] RBSEL_RESET = 16'h0000;
   localparam logic [15:0] RBSEL_WMASK = 16'h03FF;
   localparam logic [15:0] DATA_NONE = 16'h0000;
   localparam logic [7:0] ADDR_STEP = 8'h01;

   // ---------------------------------------------------------------
   // Serial framing
   // ---------------------------------------------------------------
   localparam logic [4:0] BIT_FIRST = 5'h00;
   localparam logic [4:0] BIT_LAST = 5'h1F;
   localparam logic [4:0] BIT_STEP = 5'h01;

   typedef enum logic [0:0] {
      SARR_IDLE = 1'b0,
      SARR_SHIFT = 1'b1
   } sarr_state_e;

   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] addr;
      logic [15:0] data;
   } sarr_in_word_s;

   typedef struct packed {
      logic zero;
      logic [6:0] header;
      logic [7:0] pad;
      logic [15:0] data;
   } sarr_out_word_s;

   typedef struct packed {
      logic [5:0] rsvd;
      logic auto_read;
      logic frame_header_select;
      logic [7:0] rb_addr;
   } sarr_rbsel_s;

   typedef struct packed {
      logic adc_rdy;
      logic alert_pending;
      logic alert_any;
      logic [3:0] din_comp;
   } sarr_info_s;

   // Live condition word, laid out exactly as the live status register.
   typedef struct packed {
      logic rsvd;
      logic adc_rdy;
      logic adc_busy;
      logic [2:0] adc_chan;
      logic reg1v8_live;
      logic digital_supply_live;
      logic analog_supply_live;
      logic reg5v_live;
      logic pump_live;
      logic overheat_live;
      logic chan_d_fault_live;
      logic chan_c_fault_live;
      logic chan_b_fault_live;
      logic chan_a_fault_live;
   } sarr_live_s;

endpackage

//--- rtl/sarr_sync.sv
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that may change at any time relative to clk.
`timescale 1ns/100ps
module sarr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sarr_sync_s;

   sarr_sync_s q;
   sarr_sync_s next_q;

   // Only the second stage reads the first; all logic sees the second.
   always_comb begin
      next_q.meta = async_in;
      next_q.stable = q.meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign sync_out = q.stable;

endmodule

//--- rtl/sarr_alert_gate.sv
// Alert pin gating: latched alert status against the alert mask.
// Assumes alert_status comes from the latched status register on the same clock.
`timescale 1ns/100ps
module sarr_alert_gate (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [14:0] alert_status,
   input wire logic [14:0] alert_mask,
   output logic alert_n,
   output logic alert_pending
);

   typedef struct packed {
      logic pending;
   } sarr_gate_s;

   sarr_gate_s q;
   sarr_gate_s next_q;

   always_comb begin
      next_q.pending = |(alert_status & ~alert_mask);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // The pin is active low, so a quiet device holds it high.
   assign alert_n = ~q.pending;
   assign alert_pending = q.pending;

   property p_alert_on;
      @(posedge clk) disable iff (!rst_n)
      (|(alert_status & ~alert_mask)) |=> !alert_n;
   endproperty
   a_alert_on: assert property (p_alert_on) else $error("unmasked alert did not drive the pin");

   property p_alert_masked;
      @(posedge clk) disable iff (!rst_n)
      ((alert_status & ~alert_mask) == 15'h0000) |=> alert_n;
   endproperty
   a_alert_masked: assert property (p_alert_masked) else $error("masked alert reached the pin");

endmodule

//--- tb/sarr_host.sv
// Host side model of the serial register port: frames of 32-bit words, MSB first.
// Assumes the device takes sdi on falling sclk and has its next sdo bit ready before the next rise.
`timescale 1ns/100ps
module sarr_host (
   input wire logic clk,
   output logic sclk,
   output logic sync_n,
   output logic sdi,
   input wire logic sdo
);
   logic [31:0] txw [8];
   logic [31:0] rxw [8];

   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      sdi = 1'b0;
   end

   // --------------------------------------------------------------
   // Frame driver
   // --------------------------------------------------------------
   // Half period of 8 clk gives the 160 ns link clock, which stands low outside frames.
   // A read needs the readback address written beforehand, in this frame or an earlier one.
   task automatic run(input int n);
      sync_n <= 1'b0;
      repeat (8) @(posedge clk);
      for (int w = 0; w < n; w++) begin
         for (int b = 31; b >= 0; b--) begin
            sdi <= txw[w][b];
            sclk <= 1'b1;
            repeat (8) @(posedge clk);
            rxw[w][b] = sdo;
            sclk <= 1'b0;
            repeat (8) @(posedge clk);
         end
      end
      sync_n <= 1'b1;
      // The data line is left at the inverse of its last value so no stale bit looks valid.
      sdi <= ~sdi;
      repeat (8) @(posedge clk);
   endtask
endmodule

//--- tb/sarr_core_tb.sv
// Self-checking bench of the status, alert mask and readback block.
// Assumes the serial host model in sarr_host and a 100 MHz device clock.
`timescale 1ns/100ps
module sarr_core_tb;
   logic clk;
   logic rst_n;
   logic sclk;
   logic sync_n;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   logic alert_n;
   logic [3:0] din_comp;
   logic [14:0] alert_status;
   logic [15:0] alert_mask_bits;
   sarr_pkg::sarr_live_s live_cond;
   sarr_pkg::sarr_rbsel_s readback_select;
   logic [31:0] rx;
   int error_cnt;
   int n_checks;

   sarr_core i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
      .sdo_oe(sdo_oe), .live_cond(live_cond), .din_comp(din_comp), .alert_status(alert_status),
      .alert_n(alert_n), .alert_mask_bits(alert_mask_bits), .readback_select(readback_select));

   sarr_host i_host (.clk(clk), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] wr(input logic [7:0] a, input logic [15:0] d);
      return {8'h00, a, d};
   endfunction

   function automatic logic [31:0] rd(input logic [6:0] h, input logic [15:0] d);
      return {1'b0, h, 8'h00, d};
   endfunction

   task automatic one(input logic [31:0] tx, output logic [31:0] got);
      i_host.txw[0] = tx;
      i_host.run(1);
      got = i_host.rxw[0];
   endtask

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_reset;
      chk({16'h0000, alert_mask_bits}, 32'h0000_0000);
      chk({16'h0000, readback_select}, 32'h0000_0000);
      chk({30'h0000_0000, sdo_oe, alert_n}, 32'h0000_0001);
      $display("test reset done");
   endtask

   task automatic t_two_stage;
      one(wr(sarr_pkg::ADDR_MASK, 16'hFFFF), rx);
      chk({16'h0000, alert_mask_bits}, 32'h0000_7FFF);
      one(wr(sarr_pkg::ADDR_RBSEL, 16'hFC3C), rx);
      chk(rx, rd(7'h00, 16'h0000));
      chk({16'h0000, readback_select}, 32'h0000_003C);
      one(wr(8'h00, 16'h0000), rx);
      chk(rx, rd(7'h3C, 16'h7FFF));
      one(wr(8'h00, 16'h0000), rx);
      chk(rx, rd(7'h3C, 16'h0000));
      $display("test two stage done");
   endtask

   task automatic t_live;
      logic [15:0] pat [4];
      pat = '{16'h0155, 16'h02AA, 16'hFFFF, 16'h0000};
      one(wr(sarr_pkg::ADDR_RBSEL, 16'h022F), rx);
      chk(rx, rd(7'h3C, 16'h0000));
      for (int i = 0; i < 4; i++) begin
         live_cond <= pat[i];
         repeat (4) @(posedge clk);
         one(wr(8'h00, 16'h0000), rx);
         chk(rx, rd(7'h2F, {1'b0, pat[i][14:0]}));
      end
      $display("test live done");
   endtask

   task automatic t_burst;
      logic [15:0] exp [6];
      exp = '{16'h7FFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h023C};
      one(wr(sarr_pkg::ADDR_RBSEL, 16'h023C), rx);
      chk(rx, rd(7'h2F, 16'h0000));
      for (int w = 0; w < 6; w++) begin
         i_host.txw[w] = wr(8'h00, 16'h0000);
      end
      i_host.run(6);
      for (int w = 0; w < 6; w++) begin
         chk(i_host.rxw[w], rd(7'h3C, exp[w]));
      end
      // A new frame starts again from the readback address.
      one(wr(8'h00, 16'h0000), rx);
      chk(rx, rd(7'h3C, 16'h7FFF));
      $display("test burst done");
   endtask

   task automatic t_header;
      one(wr(sarr_pkg::ADDR_RBSEL, 16'h033C), rx);
      chk(rx, rd(7'h3C, 16'h7FFF));
      live_cond <= 16'h4000;
      din_comp <= 4'hA;
      alert_status <= 15'h0001;
      repeat (4) @(posedge clk);
      // Ready set, alert fully masked so none pending, one status bit present, comparators 1010.
      one(wr(8'h00, 16'h0000), rx);
      chk(rx, rd(7'h5A, 16'h7FFF));
      $display("test header done");
   endtask

   task automatic t_alert;
      logic [15:0] m;
      for (int i = 0; i < 15; i++) begin
         m = 16'h0001 << i;
         one(wr(sarr_pkg::ADDR_MASK, m), rx);
         chk({16'h0000, alert_mask_bits}, {16'h0000, m});
         alert_status <= m[14:0];
         repeat (3) @(posedge clk);
         chk({31'h0000_0000, alert_n}, 32'h0000_0001);
         alert_status <= m[14:0] | (15'h0001 << ((i + 1) % 15));
         repeat (3) @(posedge clk);
         chk({31'h0000_0000, alert_n}, 32'h0000_0000);
      end
      alert_status <= 15'h0000;
      repeat (3) @(posedge clk);
      chk({31'h0000_0000, alert_n}, 32'h0000_0001);
      $display("test alert done");
   endtask

   // --------------------------------------------------------------
   // Main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      error_cnt = 0;
      n_checks = 0;
      rst_n = 1'b0;
      live_cond = 16'h0000;
      din_comp = 4'h0;
      alert_status = 15'h0000;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_two_stage();
      t_live();
      t_burst();
      t_header();
      t_alert();
      final_report();
   end

   // About 35 words of 512 clk each are expected; the limit leaves ample margin.
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      final_report();
   end
endmodule
